/* File: core/fan_threshold_regs.sv */
// target temperature and adaptive threshold control register bank
`timescale 1ns/1ps

module fan_threshold_regs (
   // clock and reset
   input  wire logic                             clk_in,
   input  wire logic                             arst_n_in,
   // register port
   input  wire fan_threshold_pkg::reg_req_t      req_in,
   output logic [7:0]                            rdata_out,
   // configuration from elsewhere in the device
   input  wire logic                             config_lock_in,
   input  wire logic                             twos_complement_in,
   input  wire logic                             alert_enable_in,
   input  wire logic                             standby_supply_in,
   input  wire logic [1:0]                       remote2_cycle_code_lsbs_in,
   // measurements
   input  wire fan_threshold_pkg::readings_t     readings_in,
   // pin, active low
   input  wire logic                             thermal_throttle_pin_n_in,
   // targets and control to the fan loop
   output logic [2:0][7:0]                       target_out,
   output logic [2:0][8:0]                       target_signed_out,
   output logic [2:0]                            adaptive_enable_out,
   output logic [10:0]                           remote2_decrease_wait_out,
   output logic [11:0]                           remote2_increase_wait_out,
   // supply handling
   output logic                                  core_low_status_out,
   output logic                                  alert_out,
   output logic                                  processor_hot_monitor_en_out,
   output logic                                  shutdown_block_out
);

   // -------------------------------------------------
   // state
   // -------------------------------------------------
   fan_threshold_pkg::state_t state_q;
   fan_threshold_pkg::state_t state_d;

   logic       throttle_fall;
   logic       core_low_cond;
   logic [2:0] cycle_code;

   // -------------------------------------------------
   // next state
   // -------------------------------------------------
   always_comb begin
      state_d = state_q;
      // pin passes two flops before use
      state_d.throttle_sync1 = thermal_throttle_pin_n_in;
      state_d.throttle_sync2 = state_q.throttle_sync1;
      state_d.throttle_prev  = state_q.throttle_sync2;
      throttle_fall = state_q.throttle_prev & ~state_q.throttle_sync2;

      core_low_cond = state_q.ctrl[fan_threshold_pkg::CTRL_CORE_SUPPLY_LOW_HANDLING] & standby_supply_in
                      & (readings_in.core_voltage < readings_in.core_voltage_low_limit);

      // host writes, refused while locked
      if (req_in.wr && !config_lock_in) begin
         case (req_in.addr)
            fan_threshold_pkg::REMOTE1_TARGET_TEMP_OFS: begin
               state_d.target[fan_threshold_pkg::CH_REMOTE1] = req_in.wdata;
            end
            fan_threshold_pkg::LOCAL_TARGET_TEMP_OFS: begin
               state_d.target[fan_threshold_pkg::CH_LOCAL] = req_in.wdata;
            end
            fan_threshold_pkg::REMOTE2_TARGET_TEMP_OFS: begin
               state_d.target[fan_threshold_pkg::CH_REMOTE2] = req_in.wdata;
            end
            fan_threshold_pkg::ADAPTIVE_THRESHOLD_CONTROL_OFS: begin
               state_d.ctrl = req_in.wdata;
            end
            default: begin
               state_d.ctrl = state_q.ctrl;
            end
         endcase
      end

      // capture on throttle assertion wins over a same-cycle host write, lock or not
      for (int ch = 0; ch < fan_threshold_pkg::NUM_CHANNELS; ch++) begin
         if (throttle_fall && state_q.ctrl[fan_threshold_pkg::CTRL_CAPTURE_ON_THROTTLE_LSB + ch]) begin
            state_d.target[ch] = readings_in.temp[ch];
         end
      end

      // set point in signed degrees, per format
      for (int ch = 0; ch < fan_threshold_pkg::NUM_CHANNELS; ch++) begin
         if (twos_complement_in) begin
            state_d.target_signed[ch] = {state_q.target[ch][7], state_q.target[ch]};
         end else begin
            state_d.target_signed[ch] = {1'b0, state_q.target[ch]} - fan_threshold_pkg::OFFSET64_BIAS;
         end
      end

      // read port, registered
      case (req_in.addr)
         fan_threshold_pkg::REMOTE1_TARGET_TEMP_OFS: begin
            state_d.rdata = state_q.target[fan_threshold_pkg::CH_REMOTE1];
         end
         fan_threshold_pkg::LOCAL_TARGET_TEMP_OFS: begin
            state_d.rdata = state_q.target[fan_threshold_pkg::CH_LOCAL];
         end
         fan_threshold_pkg::REMOTE2_TARGET_TEMP_OFS: begin
            state_d.rdata = state_q.target[fan_threshold_pkg::CH_REMOTE2];
         end
         fan_threshold_pkg::ADAPTIVE_THRESHOLD_CONTROL_OFS: begin
            state_d.rdata = state_q.ctrl;
         end
         default: begin
            state_d.rdata = fan_threshold_pkg::UNMAPPED_READ;
         end
      endcase
      if (!req_in.rd) begin
         state_d.rdata = state_q.rdata;
      end

      // core supply low handling; clears as soon as the condition goes
      state_d.core_low                 = core_low_cond;
      state_d.alert                    = core_low_cond & alert_enable_in;
      state_d.processor_hot_monitor_en = ~core_low_cond;
      state_d.shutdown_block           = core_low_cond;
      // adaptive enables feed the set point use in the fan loop
      state_d.adaptive_en = state_q.ctrl[fan_threshold_pkg::CTRL_ADAPTIVE_ENABLE_LSB +: 3]
                            & ~{3{core_low_cond}};

      // remote 2 wait from the full cycle code
      cycle_code = {state_q.ctrl[fan_threshold_pkg::CTRL_REMOTE2_CYCLE_CODE_MSB],
                    remote2_cycle_code_lsbs_in};
      state_d.decrease_wait = fan_threshold_pkg::DECREASE_WAIT_BASE << cycle_code;
      state_d.increase_wait = fan_threshold_pkg::INCREASE_WAIT_BASE << cycle_code;
   end

   // -------------------------------------------------
   // registers
   // -------------------------------------------------
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         state_q.throttle_sync1           <= 1'b1;
         state_q.throttle_sync2           <= 1'b1;
         state_q.throttle_prev            <= 1'b1;
         state_q.ctrl                     <= fan_threshold_pkg::CONTROL_RESET;
         state_q.target                   <= {3{fan_threshold_pkg::TARGET_TEMP_RESET}};
         state_q.target_signed            <= {3{1'b0, fan_threshold_pkg::TARGET_TEMP_RESET}};
         state_q.rdata                    <= fan_threshold_pkg::UNMAPPED_READ;
         state_q.core_low                 <= 1'b0;
         state_q.alert                    <= 1'b0;
         state_q.adaptive_en              <= 3'h0;
         state_q.processor_hot_monitor_en <= 1'b1;
         state_q.shutdown_block           <= 1'b0;
         state_q.decrease_wait            <= fan_threshold_pkg::DECREASE_WAIT_BASE;
         state_q.increase_wait            <= fan_threshold_pkg::INCREASE_WAIT_BASE;
      end else begin
         state_q <= state_d;
      end
   end

   // -------------------------------------------------
   // outputs
   // -------------------------------------------------
   assign rdata_out                    = state_q.rdata;
   assign target_out                   = state_q.target;
   assign target_signed_out            = state_q.target_signed;
   assign adaptive_enable_out          = state_q.adaptive_en;
   assign remote2_decrease_wait_out    = state_q.decrease_wait;
   assign remote2_increase_wait_out    = state_q.increase_wait;
   assign core_low_status_out          = state_q.core_low;
   assign alert_out                    = state_q.alert;
   assign processor_hot_monitor_en_out = state_q.processor_hot_monitor_en;
   assign shutdown_block_out           = state_q.shutdown_block;

   // -------------------------------------------------
   // checks
   // -------------------------------------------------
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!arst_n_in);

   AST_LOCKED_TARGET_HOLDS: assert property (
      (req_in.wr && config_lock_in && !throttle_fall
       && req_in.addr == fan_threshold_pkg::LOCAL_TARGET_TEMP_OFS)
      |=> $stable(target_out[1]))
      else $error("locked write changed local target");

   AST_LOCKED_CONTROL_HOLDS: assert property (
      (req_in.wr && config_lock_in) |=> $stable(state_q.ctrl))
      else $error("locked write changed control register");

   AST_UNLOCKED_TARGET_WRITE: assert property (
      (req_in.wr && !config_lock_in && !throttle_fall
       && req_in.addr == fan_threshold_pkg::REMOTE2_TARGET_TEMP_OFS)
      |=> target_out[2] == $past(req_in.wdata))
      else $error("unlocked write to remote 2 target lost");

   AST_CAPTURE_REMOTE1: assert property (
      (throttle_fall && state_q.ctrl[2]) |=> target_out[0] == $past(readings_in.temp[0]))
      else $error("remote 1 capture missed");

   AST_NO_CAPTURE_LOCAL: assert property (
      (throttle_fall && !state_q.ctrl[3] && !req_in.wr) |=> $stable(target_out[1]))
      else $error("local target changed without capture enable");

   AST_PIN_TO_CAPTURE: assert property (
      ($fell(thermal_throttle_pin_n_in) && state_q.ctrl[4] && state_q.throttle_sync1)
      ##1 (thermal_throttle_pin_n_in == 1'b0) [*2] ##0 $stable(state_q.ctrl)
      |=> target_out[2] == $past(readings_in.temp[2]))
      else $error("remote 2 capture not three cycles after pin fall");

   AST_CORE_LOW_EFFECTS: assert property (
      core_low_cond |=> (core_low_status_out && shutdown_block_out
                         && !processor_hot_monitor_en_out && adaptive_enable_out == 3'h0))
      else $error("core low effects missing");

   AST_CORE_RECOVER: assert property (
      (!core_low_cond ##1 !core_low_cond) |-> (processor_hot_monitor_en_out && !shutdown_block_out
                                               && adaptive_enable_out == $past(state_q.ctrl[7:5]))
      )
      else $error("functions not re-enabled after core recovery");

   AST_WAIT_DOUBLE: assert property (
      ##1 remote2_increase_wait_out == {remote2_decrease_wait_out, 1'b0})
      else $error("increase wait not twice decrease wait");

   AST_UNLOCKED_REMOTE1_WRITE: assert property (
      (req_in.wr && !config_lock_in && !throttle_fall
       && req_in.addr == fan_threshold_pkg::REMOTE1_TARGET_TEMP_OFS)
      |=> target_out[0] == $past(req_in.wdata))
      else $error("unlocked write to remote 1 target lost");

   AST_UNLOCKED_LOCAL_WRITE: assert property (
      (req_in.wr && !config_lock_in && !throttle_fall
       && req_in.addr == fan_threshold_pkg::LOCAL_TARGET_TEMP_OFS)
      |=> target_out[1] == $past(req_in.wdata))
      else $error("unlocked write to local target lost");

   AST_LOCKED_REMOTE1_HOLDS: assert property (
      (req_in.wr && config_lock_in && !throttle_fall
       && req_in.addr == fan_threshold_pkg::REMOTE1_TARGET_TEMP_OFS)
      |=> $stable(target_out[0]))
      else $error("locked write changed remote 1 target");

   AST_LOCKED_REMOTE2_HOLDS: assert property (
      (req_in.wr && config_lock_in && !throttle_fall
       && req_in.addr == fan_threshold_pkg::REMOTE2_TARGET_TEMP_OFS)
      |=> $stable(target_out[2]))
      else $error("locked write changed remote 2 target");

   AST_CONTROL_WRITE: assert property (
      (req_in.wr && !config_lock_in && req_in.addr == fan_threshold_pkg::ADAPTIVE_THRESHOLD_CONTROL_OFS)
      |=> state_q.ctrl == $past(req_in.wdata))
      else $error("unlocked control write lost");

   AST_NO_CAPTURE_REMOTE1: assert property (
      (throttle_fall && !state_q.ctrl[2] && !req_in.wr)
      |=> $stable(target_out[0]))
      else $error("remote 1 target changed without capture enable");

   AST_NO_CAPTURE_REMOTE2: assert property (
      (throttle_fall && !state_q.ctrl[4] && !req_in.wr)
      |=> $stable(target_out[2]))
      else $error("remote 2 target changed without capture enable");

   AST_CAPTURE_LOCAL: assert property (
      (throttle_fall && state_q.ctrl[3])
      |=> target_out[1] == $past(readings_in.temp[1]))
      else $error("local capture missed");

   AST_CAPTURE_REMOTE2: assert property (
      (throttle_fall && state_q.ctrl[4])
      |=> target_out[2] == $past(readings_in.temp[2]))
      else $error("remote 2 capture missed");

   AST_CAPTURE_WHILE_LOCKED: assert property (
      (throttle_fall && state_q.ctrl[3] && config_lock_in)
      |=> target_out[1] == $past(readings_in.temp[1]))
      else $error("capture blocked by lock");

   AST_FALL_NEEDS_PIN_LOW: assert property (
      throttle_fall
      |-> $past(thermal_throttle_pin_n_in, 2) == 1'b0)
      else $error("throttle edge without pin low two edges before");

   AST_FALL_ONE_SHOT: assert property (
      throttle_fall
      |=> !throttle_fall)
      else $error("throttle edge seen twice in a row");

   AST_CORE_LOW_ALERT: assert property (
      core_low_cond
      |=> alert_out == $past(alert_enable_in))
      else $error("alert does not follow its enable while core low");

   AST_ALERT_ONLY_WHEN_LOW: assert property (
      alert_out
      |-> core_low_status_out)
      else $error("alert raised without core low");

   AST_CORE_LOW_NEEDS_HANDLING: assert property (
      (!state_q.ctrl[fan_threshold_pkg::CTRL_CORE_SUPPLY_LOW_HANDLING] || !standby_supply_in)
      |=> !core_low_status_out && !shutdown_block_out)
      else $error("core low reported without handling bit or standby supply");

   AST_ADAPTIVE_FOLLOWS_CONTROL: assert property (
      !core_low_cond
      |=> adaptive_enable_out == $past(state_q.ctrl[7:5]))
      else $error("adaptive enables differ from control bits");

   AST_SIGNED_OFFSET64: assert property (
      !twos_complement_in
      |=> 9'(target_signed_out[0] + fan_threshold_pkg::OFFSET64_BIAS) == {1'b0, $past(target_out[0])})
      else $error("offset-64 set point wrong");

   AST_SIGNED_TWOS: assert property (
      twos_complement_in
      |=> target_signed_out[2] == {$past(target_out[2][7]), $past(target_out[2])})
      else $error("twos complement set point not sign extended");

   AST_DECREASE_WAIT_POWER: assert property (
      $onehot(remote2_decrease_wait_out)
      && remote2_decrease_wait_out >= fan_threshold_pkg::DECREASE_WAIT_BASE)
      else $error("decrease wait not a power of two from 8 up");

   AST_CODE_MSB_WAIT: assert property (
      state_q.ctrl[fan_threshold_pkg::CTRL_REMOTE2_CYCLE_CODE_MSB]
      |=> remote2_decrease_wait_out >= 11'h080)
      else $error("cycle code top bit not applied to remote 2 wait");

   AST_CODE_MSB_CLEAR_WAIT: assert property (
      !state_q.ctrl[fan_threshold_pkg::CTRL_REMOTE2_CYCLE_CODE_MSB]
      |=> remote2_decrease_wait_out <= 11'h040)
      else $error("cleared cycle code top bit still lengthens remote 2 wait");

   AST_READ_CONTROL: assert property (
      (req_in.rd && req_in.addr == fan_threshold_pkg::ADAPTIVE_THRESHOLD_CONTROL_OFS)
      |=> rdata_out == $past(state_q.ctrl))
      else $error("control register read back wrong");

endmodule

/* File: include/fan_threshold_pkg.sv */
// constants and carrier types for the adaptive fan-start threshold register bank
package fan_threshold_pkg;

   // -------------------------------------------------
   // register offsets
   // -------------------------------------------------
   localparam logic [7:0] REMOTE1_TARGET_TEMP_OFS        = 8'h33;
   localparam logic [7:0] LOCAL_TARGET_TEMP_OFS          = 8'h34;
   localparam logic [7:0] REMOTE2_TARGET_TEMP_OFS        = 8'h35;
   localparam logic [7:0] ADAPTIVE_THRESHOLD_CONTROL_OFS = 8'h36;

   // -------------------------------------------------
   // reset values
   // -------------------------------------------------
   localparam logic [7:0] TARGET_TEMP_RESET = 8'h64;
   localparam logic [7:0] CONTROL_RESET     = 8'h00;
   localparam logic [7:0] UNMAPPED_READ     = 8'h00;

   // -------------------------------------------------
   // control register field positions
   // -------------------------------------------------
   localparam int CTRL_REMOTE2_CYCLE_CODE_MSB  = 0;
   localparam int CTRL_CORE_SUPPLY_LOW_HANDLING = 1;
   localparam int CTRL_CAPTURE_ON_THROTTLE_LSB = 2;
   localparam int CTRL_ADAPTIVE_ENABLE_LSB     = 5;

   // -------------------------------------------------
   // channel indices and counts
   // -------------------------------------------------
   localparam int NUM_CHANNELS = 3;
   localparam int CH_REMOTE1   = 0;
   localparam int CH_LOCAL     = 1;
   localparam int CH_REMOTE2   = 2;

   // wait between adjustments, in monitoring cycles, for code 000
   localparam logic [10:0] DECREASE_WAIT_BASE = 11'h008;
   localparam logic [11:0] INCREASE_WAIT_BASE = 12'h010;
   // offset-64 temperature format bias
   localparam logic [8:0]  OFFSET64_BIAS      = 9'h040;

   // -------------------------------------------------
   // carriers
   // -------------------------------------------------
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   typedef struct packed {
      logic [NUM_CHANNELS-1:0][7:0] temp;
      logic [7:0]                   core_voltage;
      logic [7:0]                   core_voltage_low_limit;
   } readings_t;

   typedef struct packed {
      logic                               throttle_sync1;
      logic                               throttle_sync2;
      logic                               throttle_prev;
      logic [7:0]                         ctrl;
      logic [NUM_CHANNELS-1:0][7:0]       target;
      logic [NUM_CHANNELS-1:0][8:0]       target_signed;
      logic [7:0]                         rdata;
      logic                               core_low;
      logic                               alert;
      logic [NUM_CHANNELS-1:0]            adaptive_en;
      logic                               processor_hot_monitor_en;
      logic                               shutdown_block;
      logic [10:0]                        decrease_wait;
      logic [11:0]                        increase_wait;
   } state_t;

endpackage

/* File: test/reg_host_model.sv */
// host model that issues single-byte register requests
`timescale 1ns/1ps
module reg_host_model (
   // clock
   input  wire logic                   clk_in,
   // request port
   output fan_threshold_pkg::reg_req_t req_out,
   input  wire logic [7:0]             rdata_in
);
   initial begin
      req_out = '0;
   end

   // -------------------------------------------------
   // access tasks
   // -------------------------------------------------
   // released fields show inverted values so stale data never looks valid
   task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
      @(posedge clk_in);
      req_out.wr    <= 1'b1;
      req_out.addr  <= addr;
      req_out.wdata <= data;
      @(posedge clk_in);
      req_out.wr    <= 1'b0;
      req_out.addr  <= ~addr;
      req_out.wdata <= ~data;
      #1;
   endtask

   task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
      @(posedge clk_in);
      req_out.rd   <= 1'b1;
      req_out.addr <= addr;
      @(posedge clk_in);
      req_out.rd   <= 1'b0;
      req_out.addr <= ~addr;
      #1;
      data = rdata_in;
   endtask
endmodule

/* File: test/fan_threshold_regs_bench.sv */
// self-checking bench for the adaptive threshold register bank
`timescale 1ns/1ps
module fan_threshold_regs_bench;
   logic                         clk_in, arst_n_in, lock, twos, alert_en, standby, pin_n;
   logic [1:0]                   lsbs;
   fan_threshold_pkg::readings_t meas;
   fan_threshold_pkg::reg_req_t  req;
   logic [7:0]                   rdata, rd_val, pat;
   logic [2:0][7:0]              target, exp_t;
   logic [2:0][8:0]              tsigned;
   logic [2:0]                   adapt;
   logic [10:0]                  dec_wait;
   logic [11:0]                  inc_wait;
   logic                         core_low, alert, phot_en, sd_block;
   int                           miscompares, num_checks;

   reg_host_model host (.clk_in(clk_in), .req_out(req), .rdata_in(rdata));

   fan_threshold_regs uut (
      .clk_in(clk_in), .arst_n_in(arst_n_in), .req_in(req), .rdata_out(rdata),
      .config_lock_in(lock), .twos_complement_in(twos), .alert_enable_in(alert_en),
      .standby_supply_in(standby), .remote2_cycle_code_lsbs_in(lsbs), .readings_in(meas),
      .thermal_throttle_pin_n_in(pin_n), .target_out(target), .target_signed_out(tsigned),
      .adaptive_enable_out(adapt), .remote2_decrease_wait_out(dec_wait),
      .remote2_increase_wait_out(inc_wait), .core_low_status_out(core_low), .alert_out(alert),
      .processor_hot_monitor_en_out(phot_en), .shutdown_block_out(sd_block)
   );

   // -------------------------------------------------
   // helpers
   // -------------------------------------------------
   task automatic check(input logic [11:0] seen, input logic [11:0] exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask

   task automatic ticks(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask

   task automatic rdchk(input logic [7:0] addr, input logic [7:0] exp);
      host.read_reg(addr, rd_val);
      check(rd_val, exp);
   endtask

   task automatic throttle_pulse;
      @(posedge clk_in);
      pin_n <= 1'b0;
      repeat (5) @(posedge clk_in);
      pin_n <= 1'b1;
      ticks(2);
   endtask

   task automatic final_report;
      if (miscompares == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // -------------------------------------------------
   // clock, watchdog, tests
   // -------------------------------------------------
   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end

   initial begin
      #200000;
      miscompares++;
      final_report();
   end

   initial begin
      arst_n_in = 1'b0; lock = 1'b0; twos = 1'b0; alert_en = 1'b1; standby = 1'b1;
      pin_n = 1'b1; lsbs = 2'h0; meas = '0;
      meas.core_voltage = 8'h80; meas.core_voltage_low_limit = 8'h40;
      meas.temp = {8'h55, 8'h44, 8'h33};
      repeat (10) @(posedge clk_in);
      arst_n_in <= 1'b1;
      for (int i = 0; i < 3; i++) rdchk(8'(8'h33 + i), 8'h64);
      rdchk(8'h36, 8'h00);
      rdchk(8'h37, 8'h00);
      for (int i = 0; i < 3; i++) begin
         exp_t[i] = 8'(8'h50 + i);
         host.write_reg(8'(8'h33 + i), exp_t[i]);
         check(target[i], exp_t[i]);
         rdchk(8'(8'h33 + i), exp_t[i]);
      end
      check(tsigned[0], 9'h010);
      @(posedge clk_in);
      twos <= 1'b1;
      exp_t[0] = 8'hF0;
      host.write_reg(8'h33, 8'hF0);
      ticks(2);
      check(tsigned[0], 9'h1F0);
      for (int c = 0; c < 8; c++) begin
         @(posedge clk_in);
         lsbs <= 2'(c);
         host.write_reg(8'h36, {7'h70, c[2]});
         ticks(2);
         check(dec_wait, 11'h008 << c);
         check(inc_wait, 12'h010 << c);
      end
      for (int k = 0; k < 3; k++) begin
         host.write_reg(8'h36, 8'h20 << k);
         ticks(2);
         check(adapt, 3'h1 << k);
      end
      for (int k = 0; k < 2; k++) begin
         pat = k ? 8'h02 : 8'h05;
         @(posedge clk_in);
         meas.temp <= k ? {8'h88, 8'h77, 8'h66} : {8'h55, 8'h44, 8'h33};
         for (int i = 0; i < 3; i++) if (pat[i]) exp_t[i] = k ? 8'(8'h66 + 8'h11 * i) : 8'(8'h33 + 8'h11 * i);
         host.write_reg(8'h36, 8'(pat << 2));
         throttle_pulse();
         for (int i = 0; i < 3; i++) check(target[i], exp_t[i]);
      end
      @(posedge clk_in);
      lock <= 1'b1;
      meas.temp[1] <= 8'h99;
      for (int i = 0; i < 3; i++) host.write_reg(8'(8'h33 + i), 8'hAA);
      host.write_reg(8'h36, 8'hFF);
      for (int i = 0; i < 3; i++) check(target[i], exp_t[i]);
      rdchk(8'h36, 8'h08);
      throttle_pulse();
      check(target[1], 8'h99);
      @(posedge clk_in);
      lock <= 1'b0;
      host.write_reg(8'h36, 8'hE2);
      ticks(3);
      check({core_low, phot_en, sd_block, adapt}, 6'b010111);
      @(posedge clk_in);
      meas.core_voltage <= 8'h3F;
      ticks(3);
      check({core_low, alert, phot_en, sd_block, adapt}, 7'b1101000);
      @(posedge clk_in);
      alert_en <= 1'b0;
      ticks(3);
      check({core_low, alert}, 2'b10);
      @(posedge clk_in);
      standby <= 1'b0;
      ticks(3);
      check(core_low, 1'b0);
      @(posedge clk_in);
      standby <= 1'b1;
      meas.core_voltage <= 8'h40;
      ticks(3);
      check({core_low, phot_en, sd_block, adapt}, 6'b010111);
      final_report();
   end
endmodule
